// ===== asrc_ctrl.sv
`default_nettype none
// Notes on behaviour
// RQ1 - Write happens only while select, a lane enable and strobe are all low.
// RQ2 - Write data stays stable long enough before and until write end.
// RQ3 - Strobe low width covers the grade minimum for output enable state.
// RQ4 - Address and select stay valid long enough before write end.
// RQ5 - Lane enables valid long enough before write end.
// RQ6 - Address changes only after the write overlap has ended.
// RQ7 - Memory floats its outputs shortly after strobe falls.
// RQ8 - Controller releases data bus before memory drives again.
// RQ9 - Strobe may stay low across cycles; lane enables frame each write.
// RQ10 - Strobe stays high for the whole of every read.
// RQ11 - Read data valid an access delay after address change.
// RQ12 - Address valid no later than select goes low for a read.
// RQ13 - Memory floats a lane soon after its enable is removed.
// RQ14 - Memory floats all outputs soon after deselect.
// RQ15 - Output enable high some time before strobe falls.
// RQ16 - Select held high through retention; wait a read period on recovery.
// RQ17 - With select high the memory ignores controls and floats.
// RQ18 - Low enable gates bits 0-7, high enable gates bits 8-15.
// RQ19 - Strobe low means write; strobe high with output enable low reads.
// RQ20 - Clock counts cover every grade minimum before each phase change.
module asrc_ctrl (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // User request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [asrc_pkg::ASRC_ADDR_W-1:0] req_addr_in,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] req_wdata_in,
  input wire logic [1:0] req_lanes_in,
  input wire logic burst_hold_in,
  input wire logic retain_in,
  output logic req_ready_out,
  // User answer
  output logic rsp_valid_out,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] rsp_rdata_out,
  output logic retained_out,
  // Memory pins
  output logic [asrc_pkg::ASRC_ADDR_W-1:0] mem_addr_out,
  output logic chip_select_n_out,
  output logic output_enable_n_out,
  output logic write_strobe_n_out,
  output logic low_lane_enable_n_out,
  output logic high_lane_enable_n_out,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_in,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_out,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_oe_out
);
  // ==========================================================
  // State
  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_RD_WAIT, ASRC_WR_LEAD, ASRC_WR_PULSE, ASRC_WR_END, ASRC_RETAIN,
    ASRC_RECOVER
  } asrc_state_e;
  typedef struct packed {
    asrc_state_e st;
    logic [asrc_pkg::ASRC_CNT_W-1:0] cnt;
    logic [asrc_pkg::ASRC_ADDR_W-1:0] addr;
    logic [asrc_pkg::ASRC_DATA_W-1:0] wdata;
    logic drive;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [1:0] lane_n;
    logic rvalid;
    logic [asrc_pkg::ASRC_DATA_W-1:0] rdata;
  } asrc_ctrl_s;
  asrc_ctrl_s s_q, s_d;
  logic [asrc_pkg::ASRC_DATA_W-1:0] rd_sync;
  // Count load helper, truncated on purpose to the counter width
  function automatic logic [asrc_pkg::ASRC_CNT_W-1:0] asrc_load(input int unsigned c);
    asrc_load = asrc_pkg::ASRC_CNT_W'(c);
  endfunction
  // Counter step, shared by every timed phase
  function automatic logic [asrc_pkg::ASRC_CNT_W-1:0] asrc_dec(
    input logic [asrc_pkg::ASRC_CNT_W-1:0] c
  );
    asrc_dec = c - 1'b1;
  endfunction
  // A timed phase ends once its counter has run out
  function automatic logic asrc_done(input logic [asrc_pkg::ASRC_CNT_W-1:0] c);
    asrc_done = (c == '0);
  endfunction

  // ==========================================================
  // Read data enters from the pins, so it is synchronised
  asrc_sync #(
    .W(asrc_pkg::ASRC_DATA_W)
  ) u_rd_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(mem_data_in),
    .sync_out(rd_sync)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    unique case (s_q.st)
      ASRC_IDLE: begin
        if (retain_in) begin
          // Deselect before supply drops, zero lead is enough [RQ16]
          s_d.cs_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.we_n = 1'b1;
          s_d.lane_n = 2'b11;
          s_d.st = ASRC_RETAIN;
        end else if (req_valid_in && req_write_in) begin
          s_d.addr = req_addr_in; // Address set with select, zero setup [RQ4]
          s_d.wdata = req_wdata_in;
          s_d.cs_n = 1'b0;
          s_d.oe_n = 1'b1; // Outputs off ahead of strobe [RQ15]
          // Lanes latched now, since request inputs may move once taken [RQ5] [RQ18]
          s_d.lane_n = ~req_lanes_in;
          s_d.drive = 1'b0;
          if (!s_q.we_n) begin
            // Strobe held low, lane enables open this write [RQ9]
            s_d.drive = 1'b1;
            s_d.cnt = asrc_load(asrc_pkg::ASRC_STROBE_CYC);
            s_d.st = ASRC_WR_PULSE;
          end else begin
            // Strobe still high, so the open lanes store nothing yet
            s_d.cnt = asrc_load(asrc_pkg::ASRC_OFF_LEAD_CYC);
            s_d.st = ASRC_WR_LEAD;
          end
        end else if (req_valid_in) begin
          // Address and select change together [RQ12]
          s_d.addr = req_addr_in;
          s_d.cs_n = 1'b0;
          s_d.we_n = 1'b1; // Strobe high for the read [RQ10] [RQ19]
          s_d.oe_n = 1'b0;
          s_d.lane_n = ~req_lanes_in;
          s_d.drive = 1'b0;
          // Access delay plus synchroniser depth [RQ11] [RQ20]
          s_d.cnt = asrc_load(asrc_pkg::ASRC_READ_CYC + asrc_pkg::ASRC_SYNC_DEPTH);
          s_d.st = ASRC_RD_WAIT;
        end else if (!burst_hold_in) begin
          s_d.we_n = 1'b1;
          s_d.cs_n = 1'b1; // Idle deselected, memory floats [RQ17] [RQ14]
        end
      end
      ASRC_RD_WAIT: begin
        if (asrc_done(s_q.cnt)) begin
          s_d.rdata = rd_sync;
          s_d.rvalid = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.lane_n = 2'b11; // Lanes released after sampling [RQ13]
          s_d.st = ASRC_IDLE;
        end else s_d.cnt = asrc_dec(s_q.cnt);
      end
      ASRC_WR_LEAD: begin
        if (asrc_done(s_q.cnt)) begin
          // Lanes are already open, so the strobe fall starts the write
          s_d.we_n = 1'b0;
          s_d.drive = 1'b1; // Memory floats within a lead cycle [RQ7]
          // Widest strobe minimum covers both output enable cases [RQ3] [RQ20]
          s_d.cnt = asrc_load(asrc_pkg::ASRC_STROBE_CYC);
          s_d.st = ASRC_WR_PULSE;
        end else s_d.cnt = asrc_dec(s_q.cnt);
      end
      ASRC_WR_PULSE: begin
        // Overlap of select, lane and strobe stores data [RQ1]
        if (asrc_done(s_q.cnt)) begin
          // Lanes end this write; strobe kept low when burst held [RQ9]
          s_d.lane_n = 2'b11;
          if (!burst_hold_in) s_d.we_n = 1'b1;
          s_d.st = ASRC_WR_END;
        end else s_d.cnt = asrc_dec(s_q.cnt);
      end
      ASRC_WR_END: begin
        // Data held through the ending edge, then bus released [RQ2] [RQ8]
        s_d.drive = 1'b0;
        s_d.st = ASRC_IDLE; // Address may change now [RQ6]
      end
      ASRC_RETAIN: begin
        if (!retain_in) begin
          s_d.cnt = asrc_load(asrc_pkg::ASRC_RECOVER_CYC);
          s_d.st = ASRC_RECOVER;
        end
      end
      ASRC_RECOVER: begin
        // One read period before any access [RQ16]
        if (asrc_done(s_q.cnt)) s_d.st = ASRC_IDLE;
        else s_d.cnt = asrc_dec(s_q.cnt);
      end
      default: s_d.st = ASRC_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.st <= ASRC_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.lane_n <= 2'b11;
    end else s_q <= s_d;
  end

  // ==========================================================
  // Outputs; ready is combinational, pins come from flip-flops
  assign req_ready_out = (s_q.st == ASRC_IDLE) && !retain_in;
  assign rsp_valid_out = s_q.rvalid;
  assign rsp_rdata_out = s_q.rdata;
  assign retained_out = (s_q.st == ASRC_RETAIN);
  assign mem_addr_out = s_q.addr;
  assign chip_select_n_out = s_q.cs_n;
  assign output_enable_n_out = s_q.oe_n;
  assign write_strobe_n_out = s_q.we_n;
  assign low_lane_enable_n_out = s_q.lane_n[0];
  assign high_lane_enable_n_out = s_q.lane_n[1];
  assign mem_data_out = s_q.wdata;
  assign mem_data_oe_out = {asrc_pkg::ASRC_DATA_W{s_q.drive}};
endmodule
`default_nettype wire

// ===== asrc_ctrl_chk.sv
`default_nettype none
// ==========================================================
// Pin protocol checker
module asrc_ctrl_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Watched ports
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire logic retained_out,
  input wire logic [asrc_pkg::ASRC_ADDR_W-1:0] mem_addr_out,
  input wire logic chip_select_n_out,
  input wire logic output_enable_n_out,
  input wire logic write_strobe_n_out,
  input wire logic low_lane_enable_n_out,
  input wire logic high_lane_enable_n_out,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_out,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_oe_out
);
  wire ovl;
  wire rd;
  // Write overlap and read phase as the memory sees them
  assign ovl = !chip_select_n_out && !write_strobe_n_out
    && !(low_lane_enable_n_out && high_lane_enable_n_out);
  assign rd = !chip_select_n_out && !output_enable_n_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  rd_strobe_a:
    assert property (rd |-> write_strobe_n_out) else $error("strobe low in read");
  no_fight_a:
    assert property (rd |-> mem_data_oe_out == '0) else $error("bus contention");
  strobe_width_a:
    assert property ($fell(write_strobe_n_out) |-> !write_strobe_n_out [*2])
    else $error("strobe too short");
  oe_lead_a:
    assert property ($fell(write_strobe_n_out) |-> $past(output_enable_n_out))
    else $error("no output off lead");
  wdata_hold_a:
    assert property (ovl |-> mem_data_oe_out == '1 && ($past(ovl) -> $stable(mem_data_out)))
    else $error("write data moved");
  waddr_hold_a:
    assert property (ovl && $past(ovl) |-> $stable(mem_addr_out)) else $error("address moved");
  sel_setup_a:
    assert property ($fell(ovl) |-> !$past(chip_select_n_out, 2)) else $error("select late");
  raddr_hold_a:
    assert property (rd && $past(rd) |-> $stable(mem_addr_out)) else $error("read addr moved");
  rsp_time_a:
    assert property (req_valid_in && req_ready_out && !req_write_in |-> ##[6:7] rsp_valid_out)
    else $error("read answer late");
  retain_sel_a:
    assert property (retained_out |-> chip_select_n_out) else $error("selected in retention");
  // Main scenarios
  rd_c: cover property (rsp_valid_out);
  burst_c: cover property ($fell(ovl) && !write_strobe_n_out);
  ret_c: cover property (retained_out);
endmodule
bind asrc_ctrl asrc_ctrl_chk chk_u (.sys_clk_in, .rst_n_in, .req_valid_in, .req_write_in,
  .req_ready_out, .rsp_valid_out, .retained_out, .mem_addr_out, .chip_select_n_out,
  .output_enable_n_out, .write_strobe_n_out, .low_lane_enable_n_out,
  .high_lane_enable_n_out, .mem_data_out, .mem_data_oe_out);
`default_nettype wire

// ===== asrc_ctrl_tb.sv
`default_nettype none
// ==========================================================
// Self-checking bench
module asrc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [18:0] a; logic [15:0] d; logic [1:0] ln;
    logic [15:0] m;} asrc_row_s;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
  logic [18:0] req_addr_in = '0, mem_addr_out;
  logic [15:0] req_wdata_in = '0, rsp_rdata_out, mem_data_in, mem_data_out, mem_data_oe_out;
  logic [15:0] mdl_w, rd;
  logic [1:0] req_lanes_in = '0;
  logic burst_hold_in = 1'b0, retain_in = 1'b0, req_ready_out, rsp_valid_out, retained_out;
  logic chip_select_n_out, output_enable_n_out, write_strobe_n_out;
  logic low_lane_enable_n_out, high_lane_enable_n_out;
  int err_total = 0, check_count = 0, cyc = 0;
  asrc_row_s rows [8] = '{'{1, 19'h00010, 16'h1234, 2'h3, 16'hffff},
    '{1, 19'h7ffff, 16'ha55a, 2'h3, 16'hffff}, '{1, 19'h00020, 16'habcd, 2'h1, 16'hffff},
    '{1, 19'h00020, 16'hef00, 2'h2, 16'hffff}, '{0, 19'h00010, 16'h1234, 2'h3, 16'hffff},
    '{0, 19'h7ffff, 16'ha55a, 2'h3, 16'hffff}, '{0, 19'h00020, 16'hefcd, 2'h3, 16'hffff},
    '{0, 19'h00020, 16'h00cd, 2'h1, 16'h00ff}};
  asrc_ctrl dut_u (.sys_clk_in, .rst_n_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_lanes_in, .burst_hold_in, .retain_in, .req_ready_out, .rsp_valid_out,
    .rsp_rdata_out, .retained_out, .mem_addr_out, .chip_select_n_out, .output_enable_n_out,
    .write_strobe_n_out, .low_lane_enable_n_out, .high_lane_enable_n_out, .mem_data_in,
    .mem_data_out, .mem_data_oe_out);
  // Slow memory answer, still inside one access time
  asrc_sram_model #(.LAG_NS(6)) mdl_u (.sys_clk_in, .addr_in(mem_addr_out),
    .cs_n_in(chip_select_n_out), .oe_n_in(output_enable_n_out), .we_n_in(write_strobe_n_out),
    .lo_n_in(low_lane_enable_n_out), .hi_n_in(high_lane_enable_n_out),
    .wdata_in(mem_data_out), .rdata_out(mdl_w));
  // Shared wire: controller wins where it drives
  assign mem_data_in = (mem_data_oe_out & mem_data_out) | (~mem_data_oe_out & mdl_w);
  always #4 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One request; a read waits a bounded time for its answer
  task automatic req(input asrc_row_s r, output logic [15:0] q);
    int n;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= r.w;
    req_addr_in <= r.a;
    req_wdata_in <= r.d;
    req_lanes_in <= r.ln;
    n = 0;
    do @(negedge sys_clk_in); while (req_ready_out !== 1'b1 && ++n < 50);
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    if (!r.w) do @(negedge sys_clk_in); while (rsp_valid_out !== 1'b1 && ++n < 20);
    q = rsp_rdata_out & r.m;
    if (!r.w) @(posedge sys_clk_in); // Callers drive inputs only at a rising edge
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      req(rows[i], rd);
      if (!rows[i].w) chk(rd, rows[i].d, "row read");
      $display("row %0d done", i);
    end
    // Lane-framed writes with the strobe kept low
    burst_hold_in <= 1'b1;
    req('{1, 19'h00030, 16'h1111, 2'h3, 16'hffff}, rd);
    req('{1, 19'h00031, 16'h2222, 2'h3, 16'hffff}, rd);
    burst_hold_in <= 1'b0;
    req('{0, 19'h00030, 16'h0, 2'h3, 16'hffff}, rd);
    chk(rd, 16'h1111, "burst first");
    req('{0, 19'h00031, 16'h0, 2'h3, 16'hffff}, rd);
    chk(rd, 16'h2222, "burst second");
    $display("burst done");
    // Retention deselects and refuses requests
    retain_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    chk({13'h0, retained_out, chip_select_n_out, req_ready_out}, 16'h0006, "retention");
    retain_in <= 1'b0;
    // Recovery still refuses requests a read period after retention ends
    repeat (2) @(posedge sys_clk_in);
    chk({15'h0, req_ready_out}, 16'h0000, "recovery wait");
    req('{0, 19'h00010, 16'h0, 2'h3, 16'hffff}, rd);
    chk(rd, 16'h1234, "after retention");
    $display("retention done");
    // Reset in mid write idles every pin
    req_valid_in <= 1'b1;
    req_write_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    req_valid_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chk({chip_select_n_out, write_strobe_n_out, output_enable_n_out, low_lane_enable_n_out,
      high_lane_enable_n_out, mem_data_oe_out[10:0]}, 16'hf800, "reset pins");
    rst_n_in <= 1'b1;
    req('{0, 19'h7ffff, 16'h0, 2'h2, 16'hff00}, rd);
    chk(rd, 16'ha500, "after reset");
    $display("reset done");
    complete_run();
  end
endmodule
`default_nettype wire

// ===== asrc_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants of the static memory controller
package asrc_pkg;
  localparam int unsigned ASRC_ADDR_W = 19;
  localparam int unsigned ASRC_DATA_W = 16;
  localparam int unsigned ASRC_LANE_W = 8;
  localparam int unsigned ASRC_CLK_PS = 8000;
  // Grade timings in picoseconds, 10 ns grade chosen by default
  localparam int unsigned ASRC_READ_PERIOD_MIN_PS = 10000;
  localparam int unsigned ASRC_ADDRESS_TO_DATA_DELAY_PS = 10000;
  localparam int unsigned ASRC_WRITE_PERIOD_MIN_PS = 10000;
  localparam int unsigned ASRC_ADDRESS_TO_WRITE_END_PS = 8000;
  localparam int unsigned ASRC_LANE_ENABLE_TO_WRITE_END_PS = 8000;
  localparam int unsigned ASRC_STROBE_WIDTH_OUTPUTS_ON_PS = 10000;
  localparam int unsigned ASRC_WRITE_DATA_SETUP_PS = 6000;
  localparam int unsigned ASRC_STROBE_LOW_TO_FLOAT_PS = 5000;
  localparam int unsigned ASRC_STROBE_HIGH_TO_DRIVE_PS = 1000;
  localparam int unsigned ASRC_DESELECT_TO_FLOAT_PS = 4000;
  localparam int unsigned ASRC_OUTPUT_OFF_LEAD_PS = 4000;
  localparam int unsigned ASRC_RETENTION_RECOVERY_PS = ASRC_READ_PERIOD_MIN_PS;
  // Least times round up to whole cycles
  function automatic int unsigned asrc_cyc(input int unsigned ps);
    asrc_cyc = (ps + ASRC_CLK_PS - 1) / ASRC_CLK_PS;
    if (asrc_cyc < 1) asrc_cyc = 1;
  endfunction
  localparam int unsigned ASRC_OFF_LEAD_CYC = asrc_cyc(ASRC_OUTPUT_OFF_LEAD_PS);
  localparam int unsigned ASRC_READ_CYC = asrc_cyc(ASRC_ADDRESS_TO_DATA_DELAY_PS);
  localparam int unsigned ASRC_STROBE_CYC = asrc_cyc(ASRC_STROBE_WIDTH_OUTPUTS_ON_PS);
  localparam int unsigned ASRC_RECOVER_CYC = asrc_cyc(ASRC_RETENTION_RECOVERY_PS);
  localparam int unsigned ASRC_CNT_W = 4;
  // Read data passes this many synchroniser stages, then one output flip-flop, before the controller sees it
  localparam int unsigned ASRC_SYNC_DEPTH = 3;
endpackage
`default_nettype wire

// ===== asrc_sram_model.sv
`default_nettype none
// ==========================================================
// Static memory model; the clock only makes the float pattern
module asrc_sram_model #(
  parameter int unsigned LAG_NS = 0
) (
  // Clock
  input wire logic sys_clk_in,
  // Memory pins
  input wire logic [18:0] addr_in,
  input wire logic cs_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic lo_n_in,
  input wire logic hi_n_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [0:255];
  logic [15:0] junk_q = 16'h5a5a;
  logic rd_w;
  // Floating lanes toggle so a stale value never passes
  always @(posedge sys_clk_in) junk_q <= ~junk_q;
  // Store while select, strobe and a lane overlap; strobe low wins over oe
  always @* begin
    if (!cs_n_in && !we_n_in && !lo_n_in) mem_q[addr_in[7:0]][7:0] = wdata_in[7:0];
    if (!cs_n_in && !we_n_in && !hi_n_in) mem_q[addr_in[7:0]][15:8] = wdata_in[15:8];
  end
  // Drive only selected, reading, enabled lanes
  assign rd_w = !cs_n_in && we_n_in && !oe_n_in;
  assign #(LAG_NS) rdata_out[7:0] = (rd_w && !lo_n_in) ?
    mem_q[addr_in[7:0]][7:0] : junk_q[7:0];
  assign #(LAG_NS) rdata_out[15:8] = (rd_w && !hi_n_in) ?
    mem_q[addr_in[7:0]][15:8] : junk_q[15:8];
endmodule
`default_nettype wire

// ===== asrc_sync.sv
`default_nettype none
// ==========================================================
// Three-stage input synchroniser; change accepted when stages 2 and 3 agree
module asrc_sync #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } asrc_sync_s;
  asrc_sync_s st_q, st_d;
  // Stage 1 only feeds stage 2
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) st_d.q[i] = st_q.s3[i];
    end
  end
  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) st_q <= '0;
    else st_q <= st_d;
  end
  assign sync_out = st_q.q;
endmodule
`default_nettype wire
